// ===== hdl/wakeup_match_timer_pkg.sv
// Constants and state encodings shared by the wake-up match timer.
package wakeup_match_timer_pkg;

   // Elapsed-time counter and compare value width.
   localparam int CNT_W = 24;
   localparam logic [CNT_W-1:0] CNT_RESET = 24'h000000;
   localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

   // Crystal time base: oscillator edges per one-second tick.
   localparam int OSC_DIV_W = 15;
   localparam logic [OSC_DIV_W-1:0] OSC_DIV_LAST = 15'h7fff;
   localparam logic [OSC_DIV_W-1:0] OSC_DIV_RESET = 15'h0000;
   localparam logic [OSC_DIV_W-1:0] OSC_DIV_ONE = 15'h0001;

   // Debounce time for the restart pin, and the system clock period.
   localparam int DEB_TIME_NS = 1000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int DEB_CYCLES = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEB_W = 8;

   // Serial target: seven-bit address, bytes per transfer, bit counter.
   localparam logic [6:0] TARGET_ADDR = 7'h32;
   localparam logic [1:0] NUM_BYTES = 2'h3;
   localparam logic [1:0] IDX_RESET = 2'h0;
   localparam logic [1:0] IDX_ONE = 2'h1;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_RESET = 3'h0;
   localparam logic [2:0] BIT_ONE = 3'h1;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // Serial target protocol states.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ACK = 3'b010,
      ST_WDATA = 3'b011,
      ST_RDATA = 3'b100,
      ST_RACK = 3'b101
   } ser_state_t;

endpackage : wakeup_match_timer_pkg

// ===== hdl/wakeup_match_timer.sv
// Wake-up match timer: seconds counter, compare, restart debounce and serial target.

module wakeup_match_timer #(
   parameter int DEB_CYCLES = wakeup_match_timer_pkg::DEB_CYCLES,
   parameter logic [6:0] TARGET_ADDR = wakeup_match_timer_pkg::TARGET_ADDR
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic osc_in,
   input wire logic restart_n_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   output logic irq_n_out
);

   localparam int CW = wakeup_match_timer_pkg::CNT_W;
   localparam int DW = wakeup_match_timer_pkg::DEB_W;
   localparam logic [DW-1:0] DEB_LAST = DW'(DEB_CYCLES - 1);
   localparam logic [CW-1:0] CNT_ONE_L = wakeup_match_timer_pkg::CNT_ONE;

   // Two-stage synchronisers, plus one delay stage on osc, SCL and SDA for edge detection.
   logic osc_s1_ff, osc_s2_ff, osc_d_ff;
   logic rst_s1_ff, rst_s2_ff;
   logic scl_s1_ff, scl_s2_ff, scl_d_ff;
   logic sda_s1_ff, sda_s2_ff, sda_d_ff;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         {osc_s1_ff, osc_s2_ff, osc_d_ff} <= 3'h0;
         {rst_s1_ff, rst_s2_ff} <= 2'h3;
         {scl_s1_ff, scl_s2_ff, scl_d_ff} <= 3'h7;
         {sda_s1_ff, sda_s2_ff, sda_d_ff} <= 3'h7;
      end else begin
         {osc_s1_ff, osc_s2_ff, osc_d_ff} <= {osc_in, osc_s1_ff, osc_s2_ff};
         {rst_s1_ff, rst_s2_ff} <= {restart_n_in, rst_s1_ff};
         {scl_s1_ff, scl_s2_ff, scl_d_ff} <= {scl_in, scl_s1_ff, scl_s2_ff};
         {sda_s1_ff, sda_s2_ff, sda_d_ff} <= {sda_in, sda_s1_ff, sda_s2_ff};
      end
   end

   // Restart debounce: the filtered level follows the pin only after it has
   // differed for a full debounce window, so chatter never reaches the counter.
   logic deb_ff, deb_d_ff;
   logic [wakeup_match_timer_pkg::DEB_W-1:0] deb_cnt_ff, nxt_deb_cnt;
   wire deb_differs = rst_s2_ff != deb_ff;
   wire deb_flip = deb_differs && (deb_cnt_ff == DEB_LAST);
   wire restart_release = deb_ff && !deb_d_ff;
   wire running = deb_ff;
   assign nxt_deb_cnt = deb_differs ? deb_cnt_ff + 1'b1 : '0;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         deb_cnt_ff <= '0;
         deb_ff <= 1'b1;
         deb_d_ff <= 1'b1;
      end else begin
         deb_cnt_ff <= deb_flip ? '0 : nxt_deb_cnt;
         deb_ff <= deb_flip ? rst_s2_ff : deb_ff;
         deb_d_ff <= deb_ff;
      end
   end

   // One-second tick from rising edges of the synchronised crystal clock.
   logic [wakeup_match_timer_pkg::OSC_DIV_W-1:0] div_ff, nxt_div;
   logic tick_ff;
   wire osc_rise = osc_s2_ff && !osc_d_ff;
   wire div_wrap = osc_rise && (div_ff == wakeup_match_timer_pkg::OSC_DIV_LAST);
   assign nxt_div = !running ? wakeup_match_timer_pkg::OSC_DIV_RESET :
                    osc_rise ? div_ff + wakeup_match_timer_pkg::OSC_DIV_ONE : div_ff;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         div_ff <= wakeup_match_timer_pkg::OSC_DIV_RESET;
         tick_ff <= 1'b0;
      end else begin
         div_ff <= nxt_div;
         tick_ff <= running && div_wrap;
      end
   end

   // Elapsed-time counter, cleared while restart is low.
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic upd_ff;
   assign nxt_cnt = !running ? wakeup_match_timer_pkg::CNT_RESET :
                    tick_ff ? cnt_ff + wakeup_match_timer_pkg::CNT_ONE : cnt_ff;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt_ff <= wakeup_match_timer_pkg::CNT_RESET;
         upd_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         upd_ff <= running && tick_ff;
      end
   end

   // Compare and interrupt: a match is taken only when the counter has just
   // stepped onto the wake value, so a fresh write does not fire at once.
   logic [CW-1:0] wake_ff;
   logic irq_n_ff;
   wire match = running && upd_ff && (cnt_ff == wake_ff);

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         irq_n_ff <= 1'b1;
      end else if (restart_release) begin
         irq_n_ff <= 1'b1;
      end else if (match) begin
         irq_n_ff <= 1'b0;
      end
   end
   assign irq_n_out = irq_n_ff;

   // Serial bus conditions seen on the synchronised lines.
   wire scl_rise = scl_s2_ff && !scl_d_ff;
   wire scl_fall = !scl_s2_ff && scl_d_ff;
   wire bus_start = scl_s2_ff && scl_d_ff && sda_d_ff && !sda_s2_ff;
   wire bus_stop = scl_s2_ff && scl_d_ff && !sda_d_ff && sda_s2_ff;

   // Serial target state.
   wakeup_match_timer_pkg::ser_state_t st_ff;
   logic [7:0] sh_ff;
   logic [2:0] bit_ff;
   logic [1:0] idx_ff;
   logic rw_ff, byte_done_ff, drive_low_ff;
   logic [CW-1:0] shadow_ff, snap_ff;

   // Byte selection for writes into the shadow and reads from the snapshot.
   wire addr_hit = sh_ff[7:1] == TARGET_ADDR;
   wire room = idx_ff != wakeup_match_timer_pkg::NUM_BYTES;
   wire [7:0] rd_byte = (idx_ff == 2'h0) ? snap_ff[23:16] :
                        (idx_ff == 2'h1) ? snap_ff[15:8] :
                        (idx_ff == 2'h2) ? snap_ff[7:0] : wakeup_match_timer_pkg::BYTE_ZERO;
   wire [7:0] sh_in = {sh_ff[6:0], sda_s2_ff};
   wire commit = bus_stop && !room && !rw_ff && (st_ff != wakeup_match_timer_pkg::ST_IDLE);

   // Protocol engine: bits are taken on SCL rising edges and the data line
   // only changes after SCL falling edges, so the host always sees stable data.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_ff <= wakeup_match_timer_pkg::ST_IDLE;
         sh_ff <= wakeup_match_timer_pkg::BYTE_ZERO;
         bit_ff <= wakeup_match_timer_pkg::BIT_RESET;
         idx_ff <= wakeup_match_timer_pkg::IDX_RESET;
         rw_ff <= 1'b0;
         byte_done_ff <= 1'b0;
         drive_low_ff <= 1'b0;
         shadow_ff <= wakeup_match_timer_pkg::CNT_RESET;
         snap_ff <= wakeup_match_timer_pkg::CNT_RESET;
      end else if (bus_start) begin
         st_ff <= wakeup_match_timer_pkg::ST_ADDR;
         bit_ff <= wakeup_match_timer_pkg::BIT_RESET;
         idx_ff <= wakeup_match_timer_pkg::IDX_RESET;
         byte_done_ff <= 1'b0;
         drive_low_ff <= 1'b0;
      end else if (bus_stop) begin
         st_ff <= wakeup_match_timer_pkg::ST_IDLE;
         drive_low_ff <= 1'b0;
      end else begin
         unique case (st_ff)
            wakeup_match_timer_pkg::ST_IDLE: begin
               drive_low_ff <= 1'b0;
            end
            wakeup_match_timer_pkg::ST_ADDR, wakeup_match_timer_pkg::ST_WDATA: begin
               if (scl_rise) begin
                  sh_ff <= sh_in;
                  bit_ff <= bit_ff + wakeup_match_timer_pkg::BIT_ONE;
                  byte_done_ff <= bit_ff == wakeup_match_timer_pkg::BIT_LAST;
               end else if (scl_fall && byte_done_ff) begin
                  byte_done_ff <= 1'b0;
                  if (st_ff == wakeup_match_timer_pkg::ST_ADDR) begin
                     rw_ff <= sh_ff[0];
                     snap_ff <= cnt_ff;
                     st_ff <= addr_hit ? wakeup_match_timer_pkg::ST_ACK :
                              wakeup_match_timer_pkg::ST_IDLE;
                     drive_low_ff <= addr_hit;
                  end else if (room) begin
                     shadow_ff <= {shadow_ff[15:0], sh_ff};
                     idx_ff <= idx_ff + wakeup_match_timer_pkg::IDX_ONE;
                     st_ff <= wakeup_match_timer_pkg::ST_ACK;
                     drive_low_ff <= 1'b1;
                  end else begin
                     st_ff <= wakeup_match_timer_pkg::ST_IDLE;
                  end
               end
            end
            wakeup_match_timer_pkg::ST_ACK: begin
               if (scl_fall) begin
                  bit_ff <= wakeup_match_timer_pkg::BIT_RESET;
                  if (rw_ff) begin
                     st_ff <= wakeup_match_timer_pkg::ST_RDATA;
                     sh_ff <= {rd_byte[6:0], 1'b0};
                     drive_low_ff <= !rd_byte[7];
                  end else begin
                     st_ff <= wakeup_match_timer_pkg::ST_WDATA;
                     drive_low_ff <= 1'b0;
                  end
               end
            end
            wakeup_match_timer_pkg::ST_RDATA: begin
               if (scl_fall) begin
                  bit_ff <= bit_ff + wakeup_match_timer_pkg::BIT_ONE;
                  if (bit_ff == wakeup_match_timer_pkg::BIT_LAST) begin
                     st_ff <= wakeup_match_timer_pkg::ST_RACK;
                     drive_low_ff <= 1'b0;
                     idx_ff <= room ? idx_ff + wakeup_match_timer_pkg::IDX_ONE : idx_ff;
                  end else begin
                     sh_ff <= {sh_ff[6:0], 1'b0};
                     drive_low_ff <= !sh_ff[7];
                  end
               end
            end
            wakeup_match_timer_pkg::ST_RACK: begin
               if (scl_rise) begin
                  st_ff <= sda_s2_ff ? wakeup_match_timer_pkg::ST_IDLE :
                           wakeup_match_timer_pkg::ST_ACK;
               end
            end
            default: begin
               st_ff <= wakeup_match_timer_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Compare target: loaded from the shadow when a full write ends with stop.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wake_ff <= wakeup_match_timer_pkg::CNT_RESET;
      end else if (commit) begin
         wake_ff <= shadow_ff;
      end
   end

   // Open-drain data pin: the level driven is always low, the enable pulls.
   logic sda_oe_ff;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sda_oe_ff <= 1'b0;
      end else begin
         sda_oe_ff <= drive_low_ff;
      end
   end
   assign sda_oe_out = sda_oe_ff;
   assign sda_out = 1'b0;

   // Checks on the timer, restart and serial behaviour.
   property p_cnt_step;
      @(posedge clk_in) disable iff (!rstn_in)
      (running && tick_ff && $past(running)) |=> (cnt_ff == $past(cnt_ff) + CNT_ONE_L);
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("counter did not step by one");

   property p_match_irq;
      @(posedge clk_in) disable iff (!rstn_in)
      (running && upd_ff && cnt_ff == wake_ff) |=> !irq_n_out;
   endproperty
   a_match_irq: assert property (p_match_irq) else $error("match did not pull irq low");

   property p_hold_clear;
      @(posedge clk_in) disable iff (!rstn_in)
      !deb_ff |=> cnt_ff == '0 && div_ff == '0;
   endproperty
   a_hold_clear: assert property (p_hold_clear) else $error("counter not held in reset");

   property p_release_irq;
      @(posedge clk_in) disable iff (!rstn_in)
      (deb_ff && !deb_d_ff) |=> irq_n_out ##1 (cnt_ff == '0);
   endproperty
   a_release_irq: assert property (p_release_irq) else $error("release did not raise irq");

   property p_debounce;
      @(posedge clk_in) disable iff (!rstn_in)
      $changed(deb_ff) |-> $past(deb_cnt_ff) == DEB_LAST && $past(rst_s2_ff) == deb_ff;
   endproperty
   a_debounce: assert property (p_debounce) else $error("restart changed without debounce");

   property p_wake_write;
      @(posedge clk_in) disable iff (!rstn_in)
      $changed(wake_ff) |-> $past(commit) && wake_ff == $past(shadow_ff);
   endproperty
   a_wake_write: assert property (p_wake_write) else $error("wake value changed without write");

   property p_second_only;
      @(posedge clk_in) disable iff (!rstn_in)
      (running && $past(running) && !tick_ff) |=> $stable(cnt_ff);
   endproperty
   a_second_only: assert property (p_second_only) else $error("counter moved without tick");

   property p_tick_div;
      @(posedge clk_in) disable iff (!rstn_in)
      tick_ff |-> $past(div_ff) == wakeup_match_timer_pkg::OSC_DIV_LAST && $past(osc_rise);
   endproperty
   a_tick_div: assert property (p_tick_div) else $error("tick not at divider wrap");

   property p_sda_timing;
      @(posedge clk_in) disable iff (!rstn_in)
      ($rose(drive_low_ff) && !$past(bus_start)) |-> $past(scl_fall);
   endproperty
   a_sda_timing: assert property (p_sda_timing) else $error("data pulled low off clock fall");

   property p_open_drain;
      @(posedge clk_in) disable iff (!rstn_in)
      sda_oe_out |-> !sda_out;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("data line driven high");

   property p_irq_hold;
      @(posedge clk_in) disable iff (!rstn_in)
      (!irq_n_out && !(deb_ff && !deb_d_ff)) |=> !irq_n_out;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq released without restart");

endmodule : wakeup_match_timer
// wakeup_match_timer

// ===== dv/serial_host_model.sv
// Serial bus host model: drives the bus clock and pulls the data line within framed transfers.
module serial_host_model (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_oe_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // The bus clock idles high and the data line is released outside frames.
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end

   // Waits a number of falling clock edges, where every bus change is made.
   task automatic wait_q(input int n);
      repeat (n) @(negedge clk_in);
   endtask

   // One bit: data is set while the bus clock is low and sampled late in the high phase.
   task automatic bit_io(input logic b, output logic r);
      sda_oe_out = ~b;
      wait_q(10);
      scl_out = 1'b1;
      wait_q(20);
      r = sda_in;
      scl_out = 1'b0;
      wait_q(10);
   endtask

   // Start or repeated start: data falls while the bus clock is high.
   task automatic start();
      sda_oe_out = 1'b0;
      wait_q(10);
      scl_out = 1'b1;
      wait_q(10);
      sda_oe_out = 1'b1;
      wait_q(10);
      scl_out = 1'b0;
      wait_q(10);
   endtask

   // Stop: data rises while the bus clock is high, and the clock then stands still.
   task automatic stop();
      sda_oe_out = 1'b1;
      wait_q(10);
      scl_out = 1'b1;
      wait_q(10);
      sda_oe_out = 1'b0;
      wait_q(10);
   endtask

   // Sends a byte most significant bit first and returns the target's acknowledge.
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask

   // Receives a byte and answers with an acknowledge, or without one for the last byte.
   task automatic recv(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask
endmodule // serial_host_model

// ===== dv/wakeup_match_timer_bench.sv
// Self-checking bench for the wake-up match timer, with a serial host model on the bus.
module wakeup_match_timer_bench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int CYCLE_LIMIT = 90000;
   localparam logic [6:0] ADDR = wakeup_match_timer_pkg::TARGET_ADDR;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic osc = 1'b0;
   logic restart_n = 1'b1;
   logic scl;
   logic host_oe;
   logic sda_out;
   logic sda_oe;
   logic irq_n;
   wire logic sda_line;
   int errors = 0;
   int checked = 0;
   int cycles = 0;

   // Pulled-up data wire: low while either party pulls it.
   assign sda_line = ~(sda_oe | host_oe);

   // System clock at 250 MHz.
   initial begin
      forever #2 clk = ~clk;
   end

   wakeup_match_timer #(.DEB_CYCLES(4)) dut (
      .clk_in(clk), .rstn_in(rstn), .osc_in(osc), .restart_n_in(restart_n),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe),
      .irq_n_out(irq_n)
   );

   serial_host_model host (
      .clk_in(clk), .sda_in(sda_line), .scl_out(scl), .sda_oe_out(host_oe)
   );

   // Compares a seen value with the expected one and counts both.
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic end_of_test();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Cuts a hang short.
   always @(posedge clk) begin
      cycles++;
      if (cycles == CYCLE_LIMIT) begin
         errors++;
         end_of_test();
      end
   end

   // Oscillator pulses of one clock high and one low, then time for the tick to land.
   task automatic osc_pulses(input int n);
      repeat (n) begin
         osc = 1'b1;
         @(negedge clk);
         osc = 1'b0;
         @(negedge clk);
      end
      repeat (12) @(negedge clk);
   endtask

   // Holds the restart pin at a level for a number of clocks.
   task automatic pin(input logic lvl, input int n);
      restart_n = lvl;
      repeat (n) @(negedge clk);
   endtask

   // Writes a three-byte wake value and expects every byte acknowledged.
   task automatic write_wake(input logic [23:0] v);
      logic ack;
      host.start();
      host.send({ADDR, 1'b0}, ack);
      check(24'(ack), 24'h000001);
      for (int i = 2; i >= 0; i--) begin
         host.send(v[i*8 +: 8], ack);
         check(24'(ack), 24'h000001);
      end
      host.stop();
   endtask

   // Reads the counter snapshot, most significant byte first.
   task automatic read_count(input logic [23:0] exp);
      logic ack;
      logic [23:0] v;
      host.start();
      host.send({ADDR, 1'b1}, ack);
      check(24'(ack), 24'h000001);
      host.recv(1'b0, v[23:16]);
      host.recv(1'b0, v[15:8]);
      host.recv(1'b1, v[7:0]);
      host.stop();
      check(v, exp);
      check(24'(sda_out), 24'h000000);
      check(24'(sda_oe), 24'h000000);
   endtask

   // Outputs after reset.
   task automatic t_reset();
      check(24'(irq_n), 24'h000001);
      check(24'(sda_oe), 24'h000000);
   endtask

   // Wrong address is ignored; a four-byte write is refused and leaves the wake value.
   task automatic t_refused();
      logic ack;
      host.start();
      host.send({ADDR ^ 7'h01, 1'b0}, ack);
      check(24'(ack), 24'h000000);
      host.stop();
      host.start();
      host.send({ADDR, 1'b0}, ack);
      for (int i = 0; i < 3; i++) begin
         host.send(8'h01, ack);
      end
      host.send(8'h01, ack);
      check(24'(ack), 24'h000000);
      host.stop();
   endtask

   // One edge short of a second leaves the counter at zero and the interrupt high.
   task automatic t_second();
      osc_pulses(32767);
      check(24'(irq_n), 24'h000001);
      read_count(24'h000000);
   endtask

   // The last edge of the second steps onto the wake value and pulls the interrupt low.
   task automatic t_match();
      osc_pulses(1);
      check(24'(irq_n), 24'h000000);
      read_count(24'h000001);
      osc_pulses(8);
      check(24'(irq_n), 24'h000000);
   endtask

   // A restart glitch shorter than the debounce time leaves count and interrupt alone.
   task automatic t_glitch();
      pin(1'b0, 2);
      pin(1'b1, 20);
      read_count(24'h000001);
      check(24'(irq_n), 24'h000000);
   endtask

   // A held restart clears the counter but keeps the interrupt low until release.
   task automatic t_restart();
      pin(1'b0, 20);
      check(24'(irq_n), 24'h000000);
      osc_pulses(100);
      read_count(24'h000000);
      pin(1'b1, 20);
      check(24'(irq_n), 24'h000001);
      read_count(24'h000000);
   endtask

   // Main sequence.
   initial begin
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      t_reset();
      write_wake(24'h000001);
      t_refused();
      t_second();
      t_match();
      t_glitch();
      t_restart();
      end_of_test();
   end
endmodule // wakeup_match_timer_bench
